/* rtl/wrbr_pkg.sv */
// package of constants for the window row bounds register bank
// assumes an 8-bit register space behind the serial configuration port
`default_nettype none

package wrbr_pkg;

  // ----------------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] SCAN_ROW_START_OFS    = 8'h0b;
  localparam logic [7:0] SCAN_ROW_END_OFS      = 8'h0c;
  localparam logic [7:0] DISPLAY_ROW_START_OFS = 8'h0e;
  localparam logic [7:0] DISPLAY_ROW_END_OFS   = 8'h0f;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] SCAN_ROW_START_RST    = 8'h00;
  localparam logic [7:0] SCAN_ROW_END_RST      = 8'hfb;
  localparam logic [7:0] DISPLAY_ROW_START_RST = 8'h00;
  localparam logic [7:0] DISPLAY_ROW_END_RST   = 8'hfb;

  // read value for an offset that holds none of these registers
  localparam logic [7:0] UNMAPPED_READ         = 8'h00;

  // ----------------------------------------------------------------------
  // field positions inside the window low bits register
  // ----------------------------------------------------------------------
  localparam int unsigned SCAN_ADJUST_BIT      = 6;
  localparam int unsigned DISPLAY_FIRST_LSB    = 0;
  localparam int unsigned DISPLAY_LAST_LSB     = 1;

endpackage

`default_nettype wire

/* rtl/wrbr_regs.sv */
// row limit registers of the scan and display windows
// assumes the serial port decoder issues one-cycle read and write strobes
// and that the window low bits come from logic on the same clock
`default_nettype none

// Summary of operation
// - scan start row value gains one when the adjust bit is set.
// - scan start row is used unchanged when the adjust bit is clear.
// - scan end row value gains one when the adjust bit is set.
// - display start row is register value with a low bit appended.
// - display end row is register value with a low bit appended.
module wrbr_regs (
  input  wire logic       I_CLOCK,
  input  wire logic       I_RSTN,
  input  wire logic [7:0] I_REG_ADDR,
  input  wire logic       I_REG_WR,
  input  wire logic       I_REG_RD,
  input  wire logic [7:0] I_REG_WDATA,
  input  wire logic [7:0] I_WINDOW_LOW_BITS,
  output logic      [7:0] O_REG_RDATA,
  output logic            O_REG_RVALID,
  output logic      [8:0] O_SCAN_ROW_FIRST,
  output logic      [8:0] O_SCAN_ROW_LAST,
  output logic      [8:0] O_DISPLAY_ROW_FIRST,
  output logic      [8:0] O_DISPLAY_ROW_LAST
);

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  logic [7:0] scan_row_start;
  logic [7:0] scan_row_end;
  logic [7:0] display_row_start;
  logic [7:0] display_row_end;
  logic [7:0] next_scan_row_start;
  logic [7:0] next_scan_row_end;
  logic [7:0] next_display_row_start;
  logic [7:0] next_display_row_end;
  logic [7:0] next_rdata;
  logic       next_rvalid;
  logic [8:0] next_scan_first;
  logic [8:0] next_scan_last;
  logic [8:0] next_display_first;
  logic [8:0] next_display_last;
  logic       scan_adjust;

  // ----------------------------------------------------------------------
  // row arithmetic
  // ----------------------------------------------------------------------
  // widened to nine bits so that 0xff plus one does not wrap to zero
  function automatic logic [8:0] adjusted_row(input logic [7:0] msbs,
                                              input logic       adjust);
    adjusted_row = {1'b0, msbs} + {8'h00, adjust};
  endfunction

  function automatic logic [8:0] joined_row(input logic [7:0] msbs,
                                            input logic       lsb);
    joined_row = {msbs, lsb};
  endfunction

  assign scan_adjust = I_WINDOW_LOW_BITS[wrbr_pkg::SCAN_ADJUST_BIT];

  // ----------------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------------
  always_comb begin
    next_scan_row_start    = scan_row_start;
    next_scan_row_end      = scan_row_end;
    next_display_row_start = display_row_start;
    next_display_row_end   = display_row_end;
    if (I_REG_WR) begin
      unique case (I_REG_ADDR)
        wrbr_pkg::SCAN_ROW_START_OFS: begin
          next_scan_row_start = I_REG_WDATA;
        end
        wrbr_pkg::SCAN_ROW_END_OFS: begin
          next_scan_row_end = I_REG_WDATA;
        end
        wrbr_pkg::DISPLAY_ROW_START_OFS: begin
          next_display_row_start = I_REG_WDATA;
        end
        wrbr_pkg::DISPLAY_ROW_END_OFS: begin
          next_display_row_end = I_REG_WDATA;
        end
        default: begin
          // writes to other offsets belong to other blocks
        end
      endcase
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (!I_RSTN) begin
      scan_row_start    <= wrbr_pkg::SCAN_ROW_START_RST;
      scan_row_end      <= wrbr_pkg::SCAN_ROW_END_RST;
      display_row_start <= wrbr_pkg::DISPLAY_ROW_START_RST;
      display_row_end   <= wrbr_pkg::DISPLAY_ROW_END_RST;
    end else begin
      scan_row_start    <= next_scan_row_start;
      scan_row_end      <= next_scan_row_end;
      display_row_start <= next_display_row_start;
      display_row_end   <= next_display_row_end;
    end
  end

  // ----------------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------------
  // read sees the stored value, not a write in the same cycle
  always_comb begin
    next_rvalid = I_REG_RD;
    next_rdata  = wrbr_pkg::UNMAPPED_READ;
    if (I_REG_RD) begin
      unique case (I_REG_ADDR)
        wrbr_pkg::SCAN_ROW_START_OFS:    next_rdata = scan_row_start;
        wrbr_pkg::SCAN_ROW_END_OFS:      next_rdata = scan_row_end;
        wrbr_pkg::DISPLAY_ROW_START_OFS: next_rdata = display_row_start;
        wrbr_pkg::DISPLAY_ROW_END_OFS:   next_rdata = display_row_end;
        default:                         next_rdata = wrbr_pkg::UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (!I_RSTN) begin
      O_REG_RDATA  <= 8'h00;
      O_REG_RVALID <= 1'b0;
    end else begin
      O_REG_RDATA  <= next_rdata;
      O_REG_RVALID <= next_rvalid;
    end
  end

  // ----------------------------------------------------------------------
  // effective row addresses
  // ----------------------------------------------------------------------
  // registered so that outputs leave from flip-flops; one cycle behind
  always_comb begin
    next_scan_first    = adjusted_row(scan_row_start, scan_adjust);
    next_scan_last     = adjusted_row(scan_row_end, scan_adjust);
    next_display_first = joined_row(display_row_start,
      I_WINDOW_LOW_BITS[wrbr_pkg::DISPLAY_FIRST_LSB]);
    next_display_last  = joined_row(display_row_end,
      I_WINDOW_LOW_BITS[wrbr_pkg::DISPLAY_LAST_LSB]);
  end

  always_ff @(posedge I_CLOCK) begin
    if (!I_RSTN) begin
      O_SCAN_ROW_FIRST    <= 9'h000;
      O_SCAN_ROW_LAST     <= 9'h000;
      O_DISPLAY_ROW_FIRST <= 9'h000;
      O_DISPLAY_ROW_LAST  <= 9'h000;
    end else begin
      O_SCAN_ROW_FIRST    <= next_scan_first;
      O_SCAN_ROW_LAST     <= next_scan_last;
      O_DISPLAY_ROW_FIRST <= next_display_first;
      O_DISPLAY_ROW_LAST  <= next_display_last;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (!I_RSTN);

  AST_SCAN_FIRST_ADJUST: assert property (
    $past(I_RSTN) && $past(scan_adjust) |->
      O_SCAN_ROW_FIRST == {1'b0, $past(scan_row_start)} + 9'h001)
    else $error("scan first row not incremented");

  AST_SCAN_FIRST_RAW: assert property (
    $past(I_RSTN) && !$past(scan_adjust) |->
      O_SCAN_ROW_FIRST == {1'b0, $past(scan_row_start)})
    else $error("scan first row altered without adjust");

  AST_SCAN_LAST_ADJUST: assert property (
    $past(I_RSTN) |->
      O_SCAN_ROW_LAST == {1'b0, $past(scan_row_end)}
                         + {8'h00, $past(scan_adjust)})
    else $error("scan last row wrong");

  AST_DISPLAY_FIRST_JOIN: assert property (
    $past(I_RSTN) |->
      O_DISPLAY_ROW_FIRST[8:1] == $past(display_row_start) &&
      O_DISPLAY_ROW_FIRST[0] ==
        $past(I_WINDOW_LOW_BITS[wrbr_pkg::DISPLAY_FIRST_LSB]))
    else $error("display first row wrong");

  AST_DISPLAY_LAST_JOIN: assert property (
    $past(I_RSTN) |->
      O_DISPLAY_ROW_LAST ==
        {$past(display_row_end),
         $past(I_WINDOW_LOW_BITS[wrbr_pkg::DISPLAY_LAST_LSB])})
    else $error("display last row wrong");

  AST_WRITE_THEN_READ: assert property (
    I_REG_WR && !I_REG_RD && I_REG_ADDR == wrbr_pkg::SCAN_ROW_END_OFS
    ##1 I_REG_RD && !I_REG_WR && I_REG_ADDR == wrbr_pkg::SCAN_ROW_END_OFS
    |=> O_REG_RVALID && O_REG_RDATA == $past(I_REG_WDATA, 2))
    else $error("scan end row read back differs from write");

  AST_RESET_VALUES: assert property (
    @(posedge I_CLOCK) disable iff (1'b0)
    !I_RSTN |=>
      scan_row_start == wrbr_pkg::SCAN_ROW_START_RST &&
      scan_row_end == wrbr_pkg::SCAN_ROW_END_RST &&
      display_row_start == wrbr_pkg::DISPLAY_ROW_START_RST &&
      display_row_end == wrbr_pkg::DISPLAY_ROW_END_RST)
    else $error("row registers not at reset values");

  AST_UNMAPPED_ZERO: assert property (
    I_REG_RD && I_REG_ADDR == 8'h0d |=>
      O_REG_RVALID && O_REG_RDATA == wrbr_pkg::UNMAPPED_READ)
    else $error("unmapped read not zero");

  AST_HOLD_NO_WRITE: assert property (
    !I_REG_WR |=> $stable(display_row_start) && $stable(display_row_end))
    else $error("display row register changed without write");

  COV_SCAN_ADJUST_WRAP: cover property (
    scan_adjust && scan_row_end == 8'hff ##1 O_SCAN_ROW_LAST == 9'h100);
  COV_DISPLAY_WRITE: cover property (
    I_REG_WR && I_REG_ADDR == wrbr_pkg::DISPLAY_ROW_START_OFS);
  COV_READ_BACK: cover property (
    I_REG_RD && I_REG_ADDR == wrbr_pkg::DISPLAY_ROW_END_OFS);

endmodule

`default_nettype wire

/* testbench/wrbr_regs_bench.sv */
// self-checking bench for the window row bounds register bank
// assumes the bank is fed by strobes from the serial port decoder
`default_nettype none

module wrbr_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clk     = 1'b0;
  logic       rstn    = 1'b0;
  logic [7:0] addr    = 8'h00;
  logic       wr      = 1'b0;
  logic       rd      = 1'b0;
  logic [7:0] wdata   = 8'h00;
  logic [7:0] low     = 8'h00;
  logic [7:0] rdata;
  logic       rvalid;
  logic [8:0] s_first;
  logic [8:0] s_last;
  logic [8:0] d_first;
  logic [8:0] d_last;
  int         num_errors = 0;
  int         n_tests    = 0;
  int         cycles     = 0;
  logic [7:0] ofs [4]    = '{wrbr_pkg::SCAN_ROW_START_OFS,
    wrbr_pkg::SCAN_ROW_END_OFS, wrbr_pkg::DISPLAY_ROW_START_OFS,
    wrbr_pkg::DISPLAY_ROW_END_OFS};
  logic [7:0] rst_v [4]  = '{wrbr_pkg::SCAN_ROW_START_RST,
    wrbr_pkg::SCAN_ROW_END_RST, wrbr_pkg::DISPLAY_ROW_START_RST,
    wrbr_pkg::DISPLAY_ROW_END_RST};
  // 0xff in scan end checks the ninth bit on increment
  logic [7:0] new_v [4]  = '{8'h7e, 8'hff, 8'h55, 8'ha0};

  wrbr_regs uut (
    .I_CLOCK             (clk),
    .I_RSTN              (rstn),
    .I_REG_ADDR          (addr),
    .I_REG_WR            (wr),
    .I_REG_RD            (rd),
    .I_REG_WDATA         (wdata),
    .I_WINDOW_LOW_BITS   (low),
    .O_REG_RDATA         (rdata),
    .O_REG_RVALID        (rvalid),
    .O_SCAN_ROW_FIRST    (s_first),
    .O_SCAN_ROW_LAST     (s_last),
    .O_DISPLAY_ROW_FIRST (d_first),
    .O_DISPLAY_ROW_LAST  (d_last)
  );

  initial begin
    forever #25 clk = ~clk;
  end

  // ----------------------------------------------------------------------
  // compare, access and closing tasks
  // ----------------------------------------------------------------------
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk8(string what, logic [7:0] exp, logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk9(string what, logic [8:0] exp, logic [8:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reg_write(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic reg_read(logic [7:0] a, logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    chk8("read valid", 8'h01, {7'h00, rvalid});
    chk8("read data", exp, rdata);
  endtask

  // write, then a read of the same offset on the very next edge
  task automatic reg_write_read(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    rd    <= 1'b1;
    @(posedge clk);
    rd    <= 1'b0;
    #1;
    chk8("back to back valid", 8'h01, {7'h00, rvalid});
    chk8("back to back data", d, rdata);
  endtask

  // registered outputs: one edge for the cause, one for the output flop
  task automatic chk_rows(logic [8:0] sf, logic [8:0] sl,
                          logic [8:0] df, logic [8:0] dl);
    repeat (2) @(posedge clk);
    #1;
    chk9("scan first", sf, s_first);
    chk9("scan last", sl, s_last);
    chk9("display first", df, d_first);
    chk9("display last", dl, d_last);
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 4; i++) reg_read(ofs[i], rst_v[i]);
    chk_rows(9'h000, 9'h0fb, 9'h000, 9'h1f6);
    @(posedge clk);
    low <= 8'h43;
    chk_rows(9'h001, 9'h0fc, 9'h001, 9'h1f7);
    for (int i = 0; i < 4; i++) reg_write(ofs[i], new_v[i]);
    chk_rows(9'h07f, 9'h100, 9'h0ab, 9'h141);
    for (int i = 0; i < 4; i++) reg_read(ofs[i], new_v[i]);
    // adjust bit and display end low bit clear: no increment may follow
    @(posedge clk);
    low <= 8'hbd;
    chk_rows(9'h07e, 9'h0ff, 9'h0ab, 9'h140);
    reg_write(8'h0d, 8'h33);
    reg_read(8'h0d, wrbr_pkg::UNMAPPED_READ);
    reg_read(ofs[1], new_v[1]);
    reg_write_read(ofs[1], 8'h20);
    @(posedge clk);
    #1;
    chk8("idle read data", 8'h00, rdata);
    chk8("idle read valid", 8'h00, {7'h00, rvalid});
    // reset in mid-run must bring every limit back
    @(posedge clk);
    rstn <= 1'b0;
    @(posedge clk);
    rstn <= 1'b1;
    #1;
    chk9("scan last in reset", 9'h000, s_last);
    for (int i = 0; i < 4; i++) reg_read(ofs[i], rst_v[i]);
    chk_rows(9'h000, 9'h0fb, 9'h001, 9'h1f6);
    tally_and_finish();
  end

endmodule

`default_nettype wire
